//--- inc/snf_pkg.sv
// Shared constants and carrier types of the serial flash front end
package snf_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS  = 50;
	localparam int unsigned PROG_TIME_NS   = 400000;
	localparam int unsigned ERASE_TIME_NS  = 2000000;
	localparam int unsigned LOAD_TIME_NS   = 250000;
	localparam int unsigned VERIFY_TIME_NS = 1000;
	localparam int unsigned PROG_CYC   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ERASE_CYC  = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LOAD_CYC   = (LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned VERIFY_CYC = (VERIFY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TIMER_W    = 16;
	// ------------------------------------------------------------
	// Array geometry
	// ------------------------------------------------------------
	localparam int unsigned BLOCK_COUNT = 1024;
	localparam int unsigned PAGES_PER_BLOCK = 64;
	localparam int unsigned BLOCK_W = $clog2(BLOCK_COUNT);
	localparam int unsigned PAGE_W  = $clog2(PAGES_PER_BLOCK);
	localparam int unsigned COL_W   = 12;
	localparam int unsigned ROW_W   = 16;
	localparam logic [11:0] MAIN_BYTES  = 12'h800;
	localparam logic [11:0] SPARE_BYTES = 12'h040;
	localparam logic [11:0] COL_LAST    = MAIN_BYTES + SPARE_BYTES - 12'h001;
	localparam logic [9:0]  ECC_SEG_BYTES = 10'h210;
	localparam logic [4:0]  ECC_MAX_BITS  = 5'h08;
	localparam logic [7:0]  ERASED_BYTE   = 8'hff;
	localparam logic [7:0]  STATUS_RESET  = 8'h00;
	localparam int unsigned STATUS_OIP_BIT = 0;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned RX_W = 9;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		LANE_X1 = 2'b00,
		LANE_X2 = 2'b01,
		LANE_X4 = 2'b10
	} snf_lane_t;
	typedef enum logic [1:0] {
		OP_IDLE   = 2'b00,
		OP_LOAD   = 2'b01,
		OP_PULSE  = 2'b10,
		OP_VERIFY = 2'b11
	} snf_op_t;
	typedef enum logic [1:0] {
		KIND_NONE  = 2'b00,
		KIND_PROG  = 2'b01,
		KIND_ERASE = 2'b10,
		KIND_COPY  = 2'b11
	} snf_kind_t;
	typedef struct packed {
		logic [BLOCK_W-1:0] block;
		logic [PAGE_W-1:0]  page;
	} snf_row_t;
	typedef struct packed {
		logic [7:0] data;
		logic       first;
	} snf_rx_t;
endpackage

//--- hdl/snf_serial_front.sv
// Serial front end of the NAND flash: pins, receive FIFO, busy engine
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Receive FIFO with registered output stage
// ------------------------------------------------------------
module snf_fifo #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 16
) (
	// Clock and reset
	input  wire logic             i_sys_clk,
	input  wire logic             i_reset_n,
	// Fill side
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic [WIDTH-1:0]      o_out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 cnt;
		logic                        ov;
		logic [WIDTH-1:0]            od;
	} snf_fifo_st_t;
	snf_fifo_st_t q;
	snf_fifo_st_t d;
	logic         push;
	logic         pop;

	assign o_in_ready  = q.cnt != (AW+1)'(DEPTH);
	assign o_out_valid = q.ov;
	assign o_out_data  = q.od;

	always_comb begin
		d    = q;
		push = i_in_valid & o_in_ready;
		pop  = (q.cnt != '0) & (~q.ov | i_out_ready);
		if (i_out_ready) begin
			d.ov = 1'b0;
		end
		if (pop) begin
			d.od = q.mem[q.rd];
			d.ov = 1'b1;
			d.rd = q.rd + AW'(1);
		end
		if (push) begin
			d.mem[q.wr] = i_in_data;
			d.wr        = q.wr + AW'(1);
		end
		d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

module snf_serial_front #(
	parameter int unsigned PROG_CYCLES  = snf_pkg::PROG_CYC,
	parameter int unsigned ERASE_CYCLES = snf_pkg::ERASE_CYC,
	parameter int unsigned LOAD_CYCLES  = snf_pkg::LOAD_CYC
) (
	// Clock and reset
	input  wire logic              i_sys_clk,
	input  wire logic              i_reset_n,
	// Serial pins
	input  wire logic              i_sclk,
	input  wire logic              i_cs_n,
	input  wire logic [3:0]        i_io,
	output logic [3:0]             o_io,
	output logic [3:0]             o_io_oe,
	// Configuration
	input  wire logic              i_quad_enable_bit,
	input  wire snf_pkg::snf_lane_t i_lane_mode,
	input  wire logic              i_tx_phase,
	input  wire logic              i_protect_wr,
	input  wire logic [2:0]        i_protect_data,
	output logic                   o_protect_range_bit0,
	output logic                   o_protect_range_bit1,
	output logic                   o_protect_range_bit2,
	output logic                   o_write_frozen,
	output logic                   o_quad_refused,
	// Received bytes
	output logic                   o_rx_valid,
	input  wire logic              i_rx_ready,
	output logic [7:0]             o_rx_data,
	output logic                   o_rx_first,
	output logic                   o_rx_overrun,
	// Bytes to send
	input  wire logic              i_tx_valid,
	input  wire logic [7:0]        i_tx_data,
	output logic                   o_tx_ready,
	// Addressing
	input  wire logic [11:0]       i_column_address,
	input  wire logic [15:0]       i_row_address,
	input  wire logic              i_load_byte,
	output logic [11:0]            o_column_address,
	output logic                   o_column_valid,
	output logic [9:0]             o_block_index,
	output logic [5:0]             o_page_index,
	// Array operations
	input  wire logic              i_prog_start,
	input  wire logic              i_copyback_start,
	input  wire logic              i_erase_start,
	input  wire logic              i_verify_ok,
	input  wire logic              i_ecc_seg_done,
	input  wire logic [4:0]        i_ecc_err_bits,
	output logic                   o_array_pulse,
	output logic                   o_array_load,
	output logic                   o_copyback,
	output logic                   o_erase,
	output logic [11:0]            o_prog_len,
	output logic                   o_op_fail,
	output logic                   o_ecc_uncorrectable,
	output logic                   o_standby,
	output logic [7:0]             o_status
);
	localparam int unsigned TW = snf_pkg::TIMER_W;
	typedef struct packed {
		logic                sclk_p;
		logic                cs_p;
		logic                hold_p;
		logic                armed;
		logic                hold;
		logic [7:0]          rx_sh;
		logic [3:0]          rx_cnt;
		logic                rx_first;
		logic                push;
		snf_pkg::snf_rx_t    push_data;
		logic                overrun;
		logic [7:0]          tx_sh;
		logic [3:0]          tx_cnt;
		logic                tx_ready;
		logic [3:0]          io;
		logic [3:0]          oe;
		logic                quad_refused;
		logic [2:0]          prot;
		logic                frozen;
		snf_pkg::snf_op_t    op;
		snf_pkg::snf_kind_t  kind;
		logic [TW-1:0]       timer;
		logic                boot;
		logic                pulse;
		logic                load;
		logic                copy;
		logic                erase;
		logic                fail;
		logic                ecc_bad;
		logic                standby;
		logic [7:0]          status;
		logic [11:0]         col;
		logic                col_valid;
		snf_pkg::snf_row_t   row;
		logic [11:0]         len;
	} snf_state_t;
	// Select history starts low: a pin already low at reset exit is no falling edge
	localparam snf_state_t ST_RESET = '{cs_p: 1'b0, hold_p: 1'b1, rx_first: 1'b1,
		boot: 1'b1, op: snf_pkg::OP_IDLE, kind: snf_pkg::KIND_NONE,
		status: snf_pkg::STATUS_RESET, default: '0};

	snf_state_t         q;
	snf_state_t         d;
	logic               fifo_ready;
	snf_pkg::snf_rx_t   fifo_out;
	logic               rise;
	logic               fall;
	logic               hold_n;
	logic               wp_n;
	logic               active;
	logic [7:0]         byte_v;
	logic [3:0]         cnt_v;
	snf_pkg::snf_lane_t lane;

	// ------------------------------------------------------------
	// Lane helpers
	// ------------------------------------------------------------
	function automatic logic [3:0] lane_step(input snf_pkg::snf_lane_t l);
		unique case (l)
			snf_pkg::LANE_X1: lane_step = 4'h1;
			snf_pkg::LANE_X2: lane_step = 4'h2;
			snf_pkg::LANE_X4: lane_step = 4'h4;
			default:          lane_step = 4'h1;
		endcase
	endfunction

	function automatic logic [3:0] lane_mask(input snf_pkg::snf_lane_t l);
		unique case (l)
			snf_pkg::LANE_X1: lane_mask = 4'h2;
			snf_pkg::LANE_X2: lane_mask = 4'h3;
			snf_pkg::LANE_X4: lane_mask = 4'hf;
			default:          lane_mask = 4'h2;
		endcase
	endfunction

	function automatic snf_pkg::snf_row_t split_row(input logic [15:0] ra);
		split_row = ra;
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Edge detection, not idle level, so clock modes 0 and 3 behave alike
	assign rise   = i_sclk & ~q.sclk_p;
	assign fall   = ~i_sclk & q.sclk_p;
	// With quad enable the pause and protect pins are data lines
	assign hold_n = i_quad_enable_bit | i_io[3];
	assign wp_n   = i_quad_enable_bit | i_io[2];

	always_comb begin
		d = q;
		byte_v = q.tx_sh;
		cnt_v = q.rx_cnt;
		lane = ((i_lane_mode == snf_pkg::LANE_X4) && !i_quad_enable_bit) ?
			snf_pkg::LANE_X1 : i_lane_mode;
		d.quad_refused = (i_lane_mode == snf_pkg::LANE_X4) & ~i_quad_enable_bit;
		d.sclk_p = i_sclk;
		d.cs_p = i_cs_n;
		d.hold_p = hold_n;
		d.push = 1'b0;
		d.tx_ready = 1'b0;
		if (q.cs_p && !i_cs_n) begin
			d.armed = 1'b1;
			d.overrun = 1'b0;
		end
		if (i_cs_n) begin
			d.hold = 1'b0;
		end else if (!i_sclk) begin
			if (q.hold_p && !hold_n) begin
				d.hold = 1'b1;
			end else if (!q.hold_p && hold_n) begin
				d.hold = 1'b0;
			end
		end
		active = ~i_cs_n & q.armed & ~d.hold;
		if (i_cs_n) begin
			d.rx_cnt = 4'h0;
			d.tx_cnt = 4'h0;
			d.rx_first = 1'b1;
		end else if (active && rise && !i_tx_phase) begin
			unique case (lane)
				snf_pkg::LANE_X1: d.rx_sh = {q.rx_sh[6:0], i_io[0]};
				snf_pkg::LANE_X2: d.rx_sh = {q.rx_sh[5:0], i_io[1:0]};
				snf_pkg::LANE_X4: d.rx_sh = {q.rx_sh[3:0], i_io};
				default:          d.rx_sh = q.rx_sh;
			endcase
			cnt_v = q.rx_cnt + lane_step(lane);
			d.rx_cnt = cnt_v;
			if (cnt_v == 4'h8) begin
				d.push = 1'b1;
				d.push_data = '{data: d.rx_sh, first: q.rx_first};
				d.rx_first = 1'b0;
				d.rx_cnt = 4'h0;
			end
		end else if (active && fall && i_tx_phase) begin
			if (q.tx_cnt == 4'h0) begin
				// Starved reads send the erased pattern rather than stale bits
				byte_v = i_tx_valid ? i_tx_data : snf_pkg::ERASED_BYTE;
				d.tx_ready = i_tx_valid;
			end
			unique case (lane)
				snf_pkg::LANE_X1: d.io = {2'b00, byte_v[7], 1'b0};
				snf_pkg::LANE_X2: d.io = {2'b00, byte_v[7:6]};
				snf_pkg::LANE_X4: d.io = byte_v[7:4];
				default:          d.io = q.io;
			endcase
			d.tx_sh = byte_v << lane_step(lane);
			d.tx_cnt = q.tx_cnt + lane_step(lane);
			if (d.tx_cnt == 4'h8) begin
				d.tx_cnt = 4'h0;
			end
		end
		// The serial host cannot be stalled, so a full FIFO is reported
		if (q.push && !fifo_ready) begin
			d.overrun = 1'b1;
		end
		d.oe = (!i_cs_n && !d.hold && q.armed && i_tx_phase) ? lane_mask(lane) : 4'h0;
		// Protect range
		d.frozen = ~wp_n;
		if (i_protect_wr && wp_n) begin
			d.prot = i_protect_data;
		end
		// Program length, saturating at one page main area
		if (i_load_byte && (q.len < snf_pkg::MAIN_BYTES)) begin
			d.len = q.len + 12'h001;
		end
		// Address tracking while the array is free
		if ((q.op == snf_pkg::OP_IDLE) && !q.boot) begin
			d.col_valid = i_column_address <= snf_pkg::COL_LAST;
			if (d.col_valid) begin
				d.col = i_column_address;
			end
			d.row = split_row(i_row_address);
		end
		if (q.timer != '0) begin
			d.timer = q.timer - TW'(1);
		end
		unique case (q.op)
			snf_pkg::OP_IDLE: begin
				if (q.boot) begin
					d.boot = 1'b0;
					d.op = snf_pkg::OP_LOAD;
					d.row = '0;
					d.ecc_bad = 1'b0;
					d.timer = TW'(LOAD_CYCLES - 1);
				end else if (i_erase_start) begin
					d.op = snf_pkg::OP_PULSE;
					d.kind = snf_pkg::KIND_ERASE;
					d.row.page = '0;
					d.timer = TW'(ERASE_CYCLES - 1);
				end else if (i_prog_start || i_copyback_start) begin
					d.op = snf_pkg::OP_PULSE;
					d.kind = i_copyback_start ? snf_pkg::KIND_COPY : snf_pkg::KIND_PROG;
					d.timer = TW'(PROG_CYCLES - 1);
				end
			end
			snf_pkg::OP_LOAD: begin
				if (q.timer == '0) begin
					d.op = snf_pkg::OP_IDLE;
				end
			end
			snf_pkg::OP_PULSE: begin
				if (q.timer == '0) begin
					d.op = snf_pkg::OP_VERIFY;
					d.timer = TW'(snf_pkg::VERIFY_CYC - 1);
				end
			end
			snf_pkg::OP_VERIFY: begin
				if (q.timer == '0) begin
					d.op = snf_pkg::OP_IDLE;
					d.fail = ~i_verify_ok;
					d.kind = snf_pkg::KIND_NONE;
					if (q.kind != snf_pkg::KIND_ERASE) begin
						d.len = 12'h000;
					end
				end
			end
		endcase
		// Set after clear so a late segment result is not lost
		if (i_ecc_seg_done && (i_ecc_err_bits > snf_pkg::ECC_MAX_BITS)) begin
			d.ecc_bad = 1'b1;
		end
		d.pulse = d.op == snf_pkg::OP_PULSE;
		d.load = d.op == snf_pkg::OP_LOAD;
		d.copy = d.kind == snf_pkg::KIND_COPY;
		d.erase = d.kind == snf_pkg::KIND_ERASE;
		d.status = snf_pkg::STATUS_RESET;
		d.status[snf_pkg::STATUS_OIP_BIT] = d.op != snf_pkg::OP_IDLE;
		d.standby = i_cs_n & (d.op == snf_pkg::OP_IDLE);
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= ST_RESET;
		end else begin
			q <= d;
		end
	end

	snf_fifo #(
		.WIDTH(snf_pkg::RX_W),
		.DEPTH(snf_pkg::FIFO_DEPTH)
	) u_rx_fifo (
		.i_sys_clk  (i_sys_clk),
		.i_reset_n  (i_reset_n),
		.i_in_valid (q.push),
		.o_in_ready (fifo_ready),
		.i_in_data  (q.push_data),
		.o_out_valid(o_rx_valid),
		.i_out_ready(i_rx_ready),
		.o_out_data (fifo_out)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_io                 = q.io;
	assign o_io_oe              = q.oe;
	assign o_protect_range_bit0 = q.prot[0];
	assign o_protect_range_bit1 = q.prot[1];
	assign o_protect_range_bit2 = q.prot[2];
	assign o_write_frozen       = q.frozen;
	assign o_quad_refused       = q.quad_refused;
	assign o_rx_data            = fifo_out.data;
	assign o_rx_first           = fifo_out.first;
	assign o_rx_overrun         = q.overrun;
	assign o_tx_ready           = q.tx_ready;
	assign o_column_address     = q.col;
	assign o_column_valid       = q.col_valid;
	assign o_block_index        = q.row.block;
	assign o_page_index         = q.row.page;
	assign o_array_pulse        = q.pulse;
	assign o_array_load         = q.load;
	assign o_copyback           = q.copy;
	assign o_erase              = q.erase;
	assign o_prog_len           = q.len;
	assign o_op_fail            = q.fail;
	assign o_ecc_uncorrectable  = q.ecc_bad;
	assign o_standby            = q.standby;
	assign o_status             = q.status;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);

	chk_io_fall_edge: assert property ($changed(o_io) |-> $past(fall))
		else $error("data lines changed without a falling clock");
	chk_rx_rise_edge: assert property (q.push |-> $past(rise))
		else $error("byte taken without a rising clock");
	chk_cs_high_float: assert property (i_cs_n |=> (o_io_oe == 4'h0))
		else $error("lines driven while deselected");
	chk_standby_busy: assert property ($past(i_cs_n) |-> (o_standby == !o_status[0]))
		else $error("standby does not follow the busy bit");
	chk_unarmed_quiet: assert property (!q.armed |-> !q.push)
		else $error("byte taken before first select");
	chk_hold_float: assert property (q.hold |-> (o_io_oe == 4'h0))
		else $error("lines driven during pause");
	chk_quad_gated: assert property (!i_quad_enable_bit |=> (o_io_oe != 4'hf))
		else $error("four lines driven without quad enable");
	chk_prot_frozen: assert property ((!i_quad_enable_bit && !i_io[2]) |=> $stable(q.prot))
		else $error("protect bits changed while frozen");
	chk_col_bound: assert property (o_column_address <= snf_pkg::COL_LAST)
		else $error("column beyond the page");
	chk_erase_page: assert property (o_erase |-> (o_page_index == 6'h00))
		else $error("erase not block aligned");
	chk_prog_len: assert property (o_prog_len <= snf_pkg::MAIN_BYTES)
		else $error("program longer than a page");
	chk_boot_load: assert property (q.boot |=> (q.op == snf_pkg::OP_LOAD) ##1 o_array_load)
		else $error("no automatic page load at power-up");
	chk_pulse_verify: assert property ($fell(o_array_pulse) |-> (q.op == snf_pkg::OP_VERIFY))
		else $error("pulse not followed by verify");

	cov_first_byte: cover property (q.push && q.push_data.first);
	cov_op_done: cover property ((q.op == snf_pkg::OP_VERIFY) ##1 (q.op == snf_pkg::OP_IDLE));
	cov_pause: cover property ($rose(q.hold));
	cov_quad_read: cover property (o_io_oe == 4'hf);
endmodule

`default_nettype wire

//--- verification/snf_host.sv
// Host serial controller model that drives the flash pins
`timescale 1ns/1ps
`default_nettype none
module snf_host (
	// Pins
	output logic            o_sclk,
	output logic            o_cs_n,
	output logic [3:0]      o_io,
	input  wire logic [3:0] i_io
);
	logic cpol;
	// ------------------------------------------------------------
	// Framing
	// ------------------------------------------------------------
	// Select starts low, so the device has not yet seen a fall
	initial begin
		cpol = 1'b0;
		o_sclk = 1'b0;
		o_cs_n = 1'b0;
		o_io = 4'hf;
	end
	// Clock polarity only moves while deselected
	task automatic sel();
		o_cs_n = 1'b1;
		o_sclk = cpol;
		#300;
		o_cs_n = 1'b0;
		#300;
	endtask
	// Lines change with the clock low; below four lanes the pause and protect pins stay high
	task automatic xfer(input logic [7:0] b, input int w, output logic [7:0] r);
		logic [3:0] t;
		for (int i = 0; i < 8; i += w) begin
			o_sclk = 1'b0;
			t = b[7:4] >> (4 - w);
			if (w < 4) t[3:2] = 2'b11;
			if (w == 1) t[1] = ~o_io[1];
			o_io = t;
			b = b << w;
			#150;
			o_sclk = 1'b1;
			r = {r[6:0], i_io[1]};
			#150;
		end
		o_sclk = cpol;
	endtask
endmodule
`default_nettype wire

//--- verification/serial_nand_flash_interface_tb.sv
// Self-checking bench of the serial flash front end
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
	$display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module serial_nand_flash_interface_tb;
	localparam int unsigned PC = 8, EC = 16, LC = 4;
	logic i_sys_clk, i_reset_n, i_sclk, i_cs_n, i_quad_enable_bit, i_tx_phase, i_protect_wr;
	logic i_rx_ready, i_tx_valid, i_load_byte, i_prog_start, i_copyback_start, i_erase_start;
	logic i_verify_ok, i_ecc_seg_done, o_protect_range_bit0, o_protect_range_bit1;
	logic o_protect_range_bit2, o_write_frozen, o_quad_refused, o_rx_valid, o_rx_first;
	logic o_rx_overrun, o_tx_ready, o_column_valid, o_array_pulse, o_array_load, o_copyback;
	logic o_erase, o_op_fail, o_ecc_uncorrectable, o_standby;
	logic [3:0] i_io, o_io, o_io_oe, h_io;
	logic [2:0] i_protect_data;
	logic [4:0] i_ecc_err_bits;
	logic [7:0] i_tx_data, o_rx_data, o_status, sent [0:31], r;
	logic [11:0] i_column_address, o_column_address, o_prog_len;
	logic [15:0] i_row_address;
	logic [9:0] o_block_index;
	logic [5:0] o_page_index;
	logic [31:0] seed;
	snf_pkg::snf_lane_t i_lane_mode;
	int n_errors, n_compared, n, n_txr;
	// Wire level: device where it drives, host otherwise
	assign i_io = (o_io_oe & o_io) | (~o_io_oe & h_io);
	snf_serial_front #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC), .LOAD_CYCLES(LC)) dut (.*);
	snf_host host (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_io(h_io), .i_io(i_io));
	always #25 i_sys_clk = ~i_sys_clk;
	// Consumed send bytes, counted mid-cycle away from the launching edge
	always @(negedge i_sys_clk) if (o_tx_ready === 1'b1) n_txr++;
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic tick();
		@(posedge i_sys_clk);
		#1;
	endtask
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic conclude();
		$display("compared %0d mismatched %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic lim(input int k);
		if (k >= 99) begin
			n_errors++;
			conclude();
		end
	endtask
	// Pops one byte at a time until eight quiet cycles pass
	task automatic drain(output int c);
		int k;
		c = 0;
		k = 0;
		while (k < 8 && c < 32) begin
			tick();
			k++;
			if (o_rx_valid === 1'b1) begin
				`CHK(o_rx_data, sent[c])
				`CHK(o_rx_first, c == 0)
				c++;
				k = 0;
				i_rx_ready = 1'b1;
				tick();
				i_rx_ready = 1'b0;
			end
		end
	endtask
	task automatic arr(input logic er, input logic cb, input int cyc);
		int k;
		i_verify_ok = ~er;
		i_row_address = rnd();
		i_erase_start = er;
		i_prog_start = ~er & ~cb;
		i_copyback_start = cb;
		tick();
		i_erase_start = 1'b0;
		i_prog_start = 1'b0;
		i_copyback_start = 1'b0;
		`CHK(o_status, 8'h01)
		`CHK(o_erase, er)
		`CHK(o_copyback, cb)
		`CHK(o_page_index, er ? 6'h00 : i_row_address[5:0])
		`CHK(o_block_index, i_row_address[15:6])
		`CHK(o_standby, 1'b0)
		for (k = 0; o_array_pulse === 1'b1 && k < 99; k++) tick();
		lim(k);
		`CHK(k, cyc)
		for (k = 0; o_status[0] === 1'b1 && k < 99; k++) tick();
		lim(k);
		`CHK(k, snf_pkg::VERIFY_CYC)
		`CHK(o_op_fail, er)
		`CHK(o_standby, 1'b1)
		if (!er) `CHK(o_prog_len, 12'h000)
	endtask
	initial begin
		seed = 32'h6107da0d;
		i_sys_clk = 1'b0;
		{i_reset_n, i_quad_enable_bit, i_tx_phase, i_protect_wr, i_rx_ready, i_tx_valid} = '0;
		{i_load_byte, i_prog_start, i_copyback_start, i_erase_start, i_verify_ok} = '0;
		{i_ecc_seg_done, i_protect_data, i_ecc_err_bits, i_tx_data} = '0;
		{i_column_address, i_row_address} = '0;
		i_lane_mode = snf_pkg::LANE_X1;
		repeat (10) tick();
		`CHK(o_status, 8'h00)
		`CHK(o_io_oe, 4'h0)
		i_reset_n = 1'b1;
		tick();
		tick();
		`CHK(o_array_load, 1'b1)
		`CHK(o_block_index, 10'h000)
		repeat (LC + 2) tick();
		`CHK(o_status, 8'h00)
		host.xfer(8'h5a, 1, r);
		repeat (8) tick();
		`CHK(o_rx_valid, 1'b0)
		$display("test boot done");
		for (int m = 0; m < 4; m++) begin
			i_quad_enable_bit = (m == 2);
			i_lane_mode = snf_pkg::snf_lane_t'(m > 1 ? 2 : m);
			sent[0] = rnd();
			host.sel();
			host.xfer(sent[0], m == 1 ? 2 : m == 2 ? 4 : 1, r);
			`CHK(o_quad_refused, m == 3)
			drain(n);
			`CHK(n, 1)
		end
		$display("test lanes done");
		i_quad_enable_bit = 1'b0;
		i_lane_mode = snf_pkg::LANE_X1;
		host.sel();
		for (int i = 0; i < 20; i++) begin
			sent[i] = rnd();
			host.xfer(sent[i], 1, r);
		end
		`CHK(o_rx_overrun, 1'b1)
		drain(n);
		// Sixteen stored words plus the registered output stage
		`CHK(n, snf_pkg::FIFO_DEPTH + 1)
		host.sel();
		`CHK(o_rx_overrun, 1'b0)
		$display("test fifo done");
		host.cpol = 1'b1;
		for (int v = 0; v < 2; v++) begin
			i_tx_valid = v;
			i_tx_data = rnd();
			i_tx_phase = 1'b1;
			host.sel();
			host.xfer(8'hff, 1, r);
			`CHK(r, v ? i_tx_data : snf_pkg::ERASED_BYTE)
			`CHK(o_io_oe, 4'h2)
			host.o_cs_n = 1'b1;
			repeat (3) tick();
			`CHK(o_io_oe, 4'h0)
		end
		`CHK(n_txr, 1)
		host.cpol = 1'b0;
		host.sel();
		host.o_io = 4'h7;
		repeat (3) tick();
		`CHK(o_io_oe, 4'h0)
		host.o_io = 4'hf;
		repeat (3) tick();
		`CHK(o_io_oe, 4'h2)
		host.o_cs_n = 1'b1;
		i_tx_phase = 1'b0;
		$display("test read done");
		host.o_io = 4'hb;
		// Unfrozen write first, then a frozen write of the inverse must not land
		for (int q = 1; q >= 0; q--) begin
			i_quad_enable_bit = q;
			i_protect_data = q ? rnd() : ~sent[1][2:0];
			if (q) sent[1] = {5'h00, i_protect_data};
			repeat (3) tick();
			`CHK(o_write_frozen, q == 0)
			i_protect_wr = 1'b1;
			tick();
			i_protect_wr = 1'b0;
			tick();
			r = {5'h00, o_protect_range_bit2, o_protect_range_bit1, o_protect_range_bit0};
			`CHK(r, sent[1])
		end
		host.o_io = 4'hf;
		i_quad_enable_bit = 1'b0;
		for (int i = 0; i < 6; i++) begin
			i_column_address = i < 3 ? 12'h83e + i : rnd();
			tick();
			tick();
			`CHK(o_column_valid, i_column_address < 12'h840)
			if (i_column_address < 12'h840) `CHK(o_column_address, i_column_address)
		end
		for (int e = 8; e < 10; e++) begin
			i_ecc_err_bits = e;
			i_ecc_seg_done = 1'b1;
			tick();
			i_ecc_seg_done = 1'b0;
			tick();
			`CHK(o_ecc_uncorrectable, e == 9)
		end
		$display("test config done");
		i_load_byte = 1'b1;
		repeat (3) tick();
		i_load_byte = 1'b0;
		tick();
		`CHK(o_prog_len, 12'h003)
		arr(1'b0, 1'b0, PC);
		i_load_byte = 1'b1;
		repeat (2050) tick();
		i_load_byte = 1'b0;
		tick();
		`CHK(o_prog_len, 12'h800)
		arr(1'b1, 1'b0, EC);
		arr(1'b0, 1'b1, PC);
		$display("test array done");
		conclude();
	end
endmodule
`default_nettype wire
